// File: floppy_seek_sense.sv
// Purpose: command sequencer for seek, drive status, interrupt query, scan
// Assumes: host strobes are synchronous to mclk, drive pins are not
// Notes: step interval must exceed the step pulse width
`timescale 1ns/1ps
`default_nettype none
module floppy_seek_sense #(
	parameter int UNIT_CYCLES = floppy_cmd_pkg::UNIT_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic soft_rst, // software reset, same clock
	input wire logic [1:0] host_addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rd_data,
	input wire logic track0_pin, // head at track 0, selected drive
	input wire logic write_protect_pin,
	input wire logic [3:0] drive_ready_pin,
	input wire logic scan_done, // compare engine finished, one cycle
	input wire logic scan_equal, // disk data equals host data
	input wire logic scan_disk_low, // disk data below host data
	output logic scan_start,
	output logic [1:0] scan_mode,
	output logic step_pulse,
	output logic head_dir, // 1 steps in, toward higher tracks
	output logic int_req
);

	//////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		floppy_cmd_pkg::phase_type phase;
		floppy_cmd_pkg::seek_phase_type skp;
		floppy_cmd_pkg::scan_mode_type smode;
		logic [8:0][7:0] cmd; // collected command bytes
		logic [3:0] cmd_cnt;
		logic [6:0][7:0] res; // result bytes
		logic [2:0] res_len;
		logic [2:0] res_idx;
		logic [3:0][11:0] present_track; // per logical drive
		logic [11:0] target;
		logic [11:0] steps;
		logic [1:0] seek_drv;
		logic seek_head;
		logic [23:0] cnt; // delay and interval counter
		logic [7:0] pw; // step pulse width counter
		logic step_out;
		logic dir_out;
		logic [3:0] busy;
		logic [3:0] seek_pend;
		logic [3:0] seek_bad;
		logic [3:0] poll_pend;
		logic poll_done; // zero after reset: polling may report
		logic [3:0] ready_prev;
		logic sense_armed; // query result pending its first read
		logic clr_is_seek;
		logic [1:0] clr_drv;
		logic data_int;
		logic [3:0] step_rate;
		logic [6:0] delay_factor;
		logic ext_range;
		logic [7:0] rd_data;
		logic scan_start;
		logic trk0_meta, trk0_sync;
		logic wp_meta, wp_sync;
		logic [3:0] rdy_meta, rdy_sync;
	} state_type;

	state_type s_reg, s_next;
	logic [7:0] main_status; // read view of the main status byte
	logic [23:0] interval_cycles; // step spacing in clocks
	logic seek_accept; // last seek byte taken this cycle
	logic sense_exec; // interrupt query executed this cycle
	logic sense_read0; // first query result byte read
	logic [3:0] set_seek; // seek terminations this cycle
	logic [11:0] cur_track; // present track of the seeking drive

	assign cur_track = s_reg.present_track[s_reg.seek_drv];
	// rate value 0 means the longest interval
	assign interval_cycles = 24'(
		(floppy_cmd_pkg::STEP_RATE_SPAN - int'(s_reg.step_rate)) *
		UNIT_CYCLES);

	// host request is low only while the scan engine works
	assign main_status = {s_reg.phase != floppy_cmd_pkg::PH_EXEC,
		s_reg.phase == floppy_cmd_pkg::PH_RESULT, 1'b0,
		s_reg.phase != floppy_cmd_pkg::PH_CMD || s_reg.cmd_cnt != 4'h0,
		s_reg.busy};

	//////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [3:0] clr_seek, clr_poll, set_poll, set_bad, need;
		logic [7:0] op;
		floppy_cmd_pkg::cmd_type kind;
		logic [1:0] drv, pick;
		logic found, cmp_hit, cmp_met;
		logic [11:0] trk;
		s_next = s_reg;
		clr_seek = 4'h0;
		clr_poll = 4'h0;
		set_poll = 4'h0;
		set_bad = 4'h0;
		set_seek = 4'h0;
		need = 4'h0;
		op = 8'h00;
		kind = floppy_cmd_pkg::CK_INVALID;
		drv = 2'h0;
		pick = 2'h0;
		found = 1'b0;
		cmp_hit = 1'b0;
		cmp_met = 1'b0;
		trk = 12'h000;
		seek_accept = 1'b0;
		sense_exec = 1'b0;
		sense_read0 = 1'b0;
		s_next.scan_start = 1'b0;

		// pin synchronisers
		s_next.trk0_meta = track0_pin;
		s_next.trk0_sync = s_reg.trk0_meta;
		s_next.wp_meta = write_protect_pin;
		s_next.wp_sync = s_reg.wp_meta;
		s_next.rdy_meta = drive_ready_pin;
		s_next.rdy_sync = s_reg.rdy_meta;

		// step pulse width
		if (s_reg.step_out) begin
			if (s_reg.pw == 8'h00) begin
				s_next.step_out = 1'b0;
			end else begin
				s_next.pw = s_reg.pw - 8'h01;
			end
		end

		// seek engine
		case (s_reg.skp)
			floppy_cmd_pkg::SK_DELAY: begin
				if (s_reg.cnt != 24'h0) begin
					s_next.cnt = s_reg.cnt - 24'h1;
				end else if (s_reg.target == cur_track) begin
					s_next.skp = floppy_cmd_pkg::SK_IDLE;
					set_seek[s_reg.seek_drv] = 1'b1;
				end else begin
					// steps and direction from the track compare
					s_next.dir_out = s_reg.target > cur_track;
					s_next.steps = (s_reg.target > cur_track) ?
						s_reg.target - cur_track :
						cur_track - s_reg.target;
					s_next.skp = floppy_cmd_pkg::SK_STEP;
					s_next.cnt = 24'h0;
				end
			end
			floppy_cmd_pkg::SK_STEP: begin
				if (s_reg.cnt != 24'h0) begin
					s_next.cnt = s_reg.cnt - 24'h1;
				end else if (s_reg.steps == 12'h000) begin
					// one full interval after the last pulse
					s_next.skp = floppy_cmd_pkg::SK_IDLE;
					set_seek[s_reg.seek_drv] = 1'b1;
				end else if (!s_reg.dir_out && s_reg.trk0_sync) begin
					// track 0 reached early: head position is known
					s_next.skp = floppy_cmd_pkg::SK_IDLE;
					s_next.present_track[s_reg.seek_drv] = 12'h000;
					set_seek[s_reg.seek_drv] = 1'b1;
					set_bad[s_reg.seek_drv] = 1'b1;
				end else begin
					s_next.step_out = 1'b1;
					s_next.pw = 8'(floppy_cmd_pkg::STEP_PULSE_CYCLES - 1);
					s_next.steps = s_reg.steps - 12'h001;
					s_next.cnt = interval_cycles - 24'h1;
					// track follows each pulse, ends on target
					s_next.present_track[s_reg.seek_drv] = s_reg.dir_out ?
						cur_track + 12'h001 : cur_track - 12'h001;
				end
			end
			default: begin
			end
		endcase
		if (set_seek != 4'h0) begin
			s_next.busy = s_reg.busy & ~set_seek;
		end

		// drive polling: ready edges only until the first command
		for (int d = 0; d < 4; d++) begin
			if (!s_reg.poll_done && s_reg.rdy_sync[d] &&
				!s_reg.ready_prev[d]) begin
				set_poll[d] = 1'b1;
			end
		end
		s_next.ready_prev = s_reg.rdy_sync;

		// host read
		if (rd_stb) begin
			if (host_addr == floppy_cmd_pkg::ADDR_MAIN_STATUS) begin
				s_next.rd_data = main_status;
			end else if (host_addr == floppy_cmd_pkg::ADDR_DATA) begin
				s_next.data_int = 1'b0;
				if (s_reg.phase == floppy_cmd_pkg::PH_RESULT) begin
					s_next.rd_data = s_reg.res[s_reg.res_idx];
					s_next.res_idx = s_reg.res_idx + 3'h1;
					if (s_reg.res_idx == 3'h0 && s_reg.sense_armed) begin
						sense_read0 = 1'b1;
						s_next.sense_armed = 1'b0;
						if (s_reg.clr_is_seek) begin
							clr_seek[s_reg.clr_drv] = 1'b1;
						end else begin
							clr_poll[s_reg.clr_drv] = 1'b1;
						end
					end
					if (s_reg.res_idx + 3'h1 == s_reg.res_len) begin
						s_next.phase = floppy_cmd_pkg::PH_CMD;
					end
				end else begin
					s_next.rd_data = 8'h00;
				end
			end else if (host_addr == floppy_cmd_pkg::ADDR_MODE) begin
				s_next.rd_data = {7'h00, s_reg.ext_range};
			end else begin
				s_next.rd_data = 8'h00;
			end
		end

		// host write: mode register and command bytes
		if (wr_stb && host_addr == floppy_cmd_pkg::ADDR_MODE) begin
			s_next.ext_range = wr_data[floppy_cmd_pkg::MODE_EXT_RANGE_BIT];
		end
		if (wr_stb && host_addr == floppy_cmd_pkg::ADDR_DATA) begin
			s_next.data_int = 1'b0;
		end
		if (wr_stb && host_addr == floppy_cmd_pkg::ADDR_DATA &&
			s_reg.phase == floppy_cmd_pkg::PH_CMD) begin
			op = (s_reg.cmd_cnt == 4'h0) ? wr_data : s_reg.cmd[0];
			kind = floppy_cmd_pkg::decode(op);
			need = floppy_cmd_pkg::cmd_length(kind, s_reg.ext_range);
			s_next.cmd[s_reg.cmd_cnt] = wr_data;
			s_next.poll_done = 1'b1;
			s_next.cmd_cnt = s_reg.cmd_cnt + 4'h1;
			if (s_reg.cmd_cnt + 4'h1 == need) begin
				s_next.cmd_cnt = 4'h0;
				s_next.res_idx = 3'h0;
				s_next.res_len = 3'h0;
				drv = s_next.cmd[1][1:0];
				case (kind)
					floppy_cmd_pkg::CK_SEEK: begin
						// opcode, head and drive, track, maybe nibble
						seek_accept = 1'b1;
						s_next.target = s_reg.ext_range ?
							{s_next.cmd[3][7:4], s_next.cmd[2]} :
							{4'h0, s_next.cmd[2]};
						s_next.seek_drv = drv;
						s_next.seek_head = s_next.cmd[1][2];
						s_next.busy[drv] = 1'b1;
						s_next.skp = floppy_cmd_pkg::SK_DELAY;
						s_next.cnt = 24'(int'(s_reg.delay_factor) *
							UNIT_CYCLES);
					end
					floppy_cmd_pkg::CK_SENSE_DRIVE: begin
						s_next.res[0] = 8'h00;
						s_next.res[0][floppy_cmd_pkg::WRITE_PROTECT_BIT] =
							s_reg.wp_sync;
						s_next.res[0][floppy_cmd_pkg::TRACK0_BIT] =
							s_reg.trk0_sync;
						s_next.res[0][2:0] = s_next.cmd[1][2:0];
						s_next.res_len = 3'h1;
					end
					floppy_cmd_pkg::CK_SENSE_INT: begin
						sense_exec = 1'b1;
						// seek terminations first, lowest drive first
						for (int d = 3; d >= 0; d--) begin
							if (s_reg.poll_pend[d]) begin
								pick = 2'(d);
								found = 1'b1;
							end
						end
						s_next.clr_is_seek = 1'b0;
						for (int d = 3; d >= 0; d--) begin
							if (s_reg.seek_pend[d]) begin
								pick = 2'(d);
								found = 1'b1;
								s_next.clr_is_seek = 1'b1;
							end
						end
						if (!found) begin
							s_next.res[0] = floppy_cmd_pkg::INVALID_STATUS;
							s_next.res_len = 3'h1;
						end else begin
							trk = s_reg.present_track[pick];
							s_next.res[0] = {floppy_cmd_pkg::CODE_POLL_READY,
								3'h0, pick};
							if (s_next.clr_is_seek) begin
								s_next.res[0] = {s_reg.seek_bad[pick] ?
									floppy_cmd_pkg::CODE_SEEK_BAD :
									floppy_cmd_pkg::CODE_SEEK_OK, 2'h0,
									s_reg.seek_head, pick};
							end
							s_next.res[1] = trk[7:0];
							s_next.res[2] = {trk[11:8], 4'h0};
							s_next.res_len = s_reg.ext_range ? 3'h3 : 3'h2;
							s_next.clr_drv = pick;
							s_next.sense_armed = 1'b1;
						end
					end
					floppy_cmd_pkg::CK_SPECIFY: begin
						s_next.step_rate = s_next.cmd[1][7:4];
						s_next.delay_factor = s_next.cmd[2][7:1];
					end
					floppy_cmd_pkg::CK_SET_TRACK: begin
						// byte chosen by opcode bit 6 and high-byte bit
						if (s_next.cmd[0][6] && s_next.cmd[1][2]) begin
							s_next.present_track[drv][11:8] =
								s_next.cmd[2][3:0];
						end else if (s_next.cmd[0][6]) begin
							s_next.present_track[drv][7:0] =
								s_next.cmd[2];
						end
						trk = s_next.present_track[drv];
						s_next.res[0] = s_next.cmd[1][2] ?
							{4'h0, trk[11:8]} : trk[7:0];
						s_next.res_len = 3'h1;
					end
					floppy_cmd_pkg::CK_SCAN: begin
						s_next.scan_start = 1'b1;
						s_next.phase = floppy_cmd_pkg::PH_EXEC;
						if ((op & floppy_cmd_pkg::SCAN_MASK) ==
							floppy_cmd_pkg::OP_SCAN_LOW) begin
							s_next.smode = floppy_cmd_pkg::SM_LOW;
						end else if ((op & floppy_cmd_pkg::SCAN_MASK) ==
							floppy_cmd_pkg::OP_SCAN_HIGH) begin
							s_next.smode = floppy_cmd_pkg::SM_HIGH;
						end else begin
							s_next.smode = floppy_cmd_pkg::SM_EQUAL;
						end
					end
					default: begin
						s_next.res[0] = floppy_cmd_pkg::INVALID_STATUS;
						s_next.res_len = 3'h1;
					end
				endcase
				if (kind != floppy_cmd_pkg::CK_SCAN) begin
					s_next.phase = (s_next.res_len == 3'h0) ?
						floppy_cmd_pkg::PH_CMD : floppy_cmd_pkg::PH_RESULT;
				end
			end
		end

		// scan completion builds the seven result bytes
		if (s_reg.phase == floppy_cmd_pkg::PH_EXEC && scan_done) begin
			cmp_hit = scan_equal;
			cmp_met = (s_reg.smode == floppy_cmd_pkg::SM_LOW) ?
				scan_disk_low : !scan_disk_low;
			s_next.res[0] = {5'h00, s_reg.cmd[1][2:0]};
			s_next.res[1] = 8'h00;
			s_next.res[2] = 8'h00;
			s_next.res[2][floppy_cmd_pkg::SCAN_HIT_BIT] = cmp_hit;
			s_next.res[2][floppy_cmd_pkg::SCAN_MISS_BIT] =
				(s_reg.smode == floppy_cmd_pkg::SM_EQUAL) ? !cmp_hit :
				(!cmp_hit && !cmp_met);
			s_next.res[3] = s_reg.cmd[2];
			s_next.res[4] = s_reg.cmd[3];
			s_next.res[5] = s_reg.cmd[4];
			s_next.res[6] = s_reg.cmd[5];
			s_next.res_len = floppy_cmd_pkg::RES_SCAN;
			s_next.res_idx = 3'h0;
			s_next.phase = floppy_cmd_pkg::PH_RESULT;
			s_next.data_int = 1'b1;
		end

		// pending causes: a new termination wins over a clear
		s_next.seek_pend = (s_reg.seek_pend & ~clr_seek) | set_seek;
		s_next.seek_bad = (s_reg.seek_bad & ~set_seek) | set_bad;
		s_next.poll_pend = (s_reg.poll_pend & ~clr_poll) | set_poll;

		// software reset keeps timing setup and mode
		if (soft_rst) begin
			s_next = '0;
			s_next.step_rate = s_reg.step_rate;
			s_next.delay_factor = s_reg.delay_factor;
			s_next.ext_range = s_reg.ext_range;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data = s_reg.rd_data;
	assign step_pulse = s_reg.step_out;
	assign head_dir = s_reg.dir_out;
	assign scan_start = s_reg.scan_start;
	assign scan_mode = s_reg.smode;
	// seek/poll causes wait for a query, data causes self clear
	assign int_req = (|s_reg.seek_pend) | (|s_reg.poll_pend) |
		s_reg.data_int;

	//////////////////////////////////////////////////////////////////////
	// checks

	logic [23:0] since_rise; // clocks since the last step rise
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			since_rise <= 24'h0;
		end else if (s_next.step_out && !s_reg.step_out) begin
			since_rise <= 24'h0;
		end else begin
			since_rise <= since_rise + 24'h1;
		end
	end

	default clocking chk_cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence seq_scan_end;
		s_reg.phase == floppy_cmd_pkg::PH_EXEC && scan_done && !soft_rst;
	endsequence
	sequence seq_last_pulse_gone;
		s_reg.skp == floppy_cmd_pkg::SK_STEP && set_seek != 4'h0;
	endsequence

	a_busy_on_seek: assert property (seek_accept && !soft_rst |=>
		s_reg.busy[s_reg.seek_drv] && s_reg.skp == floppy_cmd_pkg::SK_DELAY)
		else $error("seek accepted without busy bit");
	a_delay_quiet: assert property (
		s_reg.skp == floppy_cmd_pkg::SK_DELAY |=> !$rose(step_pulse))
		else $error("step pulse during start delay");
	a_step_dir: assert property ($rose(step_pulse) |->
		(head_dir ? s_reg.target >= cur_track : s_reg.target <= cur_track))
		else $error("head direction away from target");
	a_step_spacing: assert property ($rose(step_pulse) &&
		$past(s_reg.skp == floppy_cmd_pkg::SK_STEP, 2) |->
		$past(since_rise) == interval_cycles - 24'h1)
		else $error("step spacing differs from step rate");
	a_int_period: assert property (seq_last_pulse_gone and
		(s_reg.steps == 12'h000) |-> since_rise == interval_cycles - 24'h1
		##1 int_req)
		else $error("seek interrupt not one period after pulse");
	a_scan_equal_bits: assert property (seq_scan_end and
		(s_reg.smode == floppy_cmd_pkg::SM_EQUAL) |=>
		s_reg.res[2][3:2] == ($past(scan_equal) ? 2'h2 : 2'h1) &&
		s_reg.res_len == 3'h7)
		else $error("scan equal status bits wrong");
	a_scan_range_bits: assert property (seq_scan_end and
		(s_reg.smode == floppy_cmd_pkg::SM_HIGH && !scan_equal &&
		scan_disk_low) |=> s_reg.res[2][3:2] == 2'h1)
		else $error("scan high failed condition not reported");
	a_query_invalid: assert property (sense_exec && !soft_rst &&
		s_reg.seek_pend == 4'h0 && s_reg.poll_pend == 4'h0 |=>
		s_reg.res[0] == floppy_cmd_pkg::INVALID_STATUS &&
		s_reg.res_len == 3'h1)
		else $error("empty query not invalid");
	a_clear_first: assert property (sense_read0 && s_reg.clr_is_seek &&
		!set_seek[s_reg.clr_drv] && !soft_rst |=>
		!s_reg.seek_pend[$past(s_reg.clr_drv)])
		else $error("seek cause not cleared on first read");
	a_request_flag: assert property (
		s_reg.phase == floppy_cmd_pkg::PH_RESULT |-> main_status[7])
		else $error("request flag low in result phase");
	a_no_step_equal: assert property (s_reg.skp == floppy_cmd_pkg::SK_DELAY
		&& s_reg.cnt == 24'h0 && s_reg.target == cur_track && !soft_rst
		|=> s_reg.skp == floppy_cmd_pkg::SK_IDLE ##1 !$rose(step_pulse))
		else $error("steps issued for equal tracks");

endmodule // floppy_seek_sense
`default_nettype wire

// File: floppy_cmd_pkg.sv
// Purpose: constants and types for the floppy seek and sense sequencer
// Assumes: 25 MHz controller clock, 8-bit command and result bytes
// Notes: drive pins arrive unsynchronised; the scan data engine is outside
package floppy_cmd_pkg;

	// host port addresses
	localparam logic [1:0] ADDR_MAIN_STATUS = 2'h0;
	localparam logic [1:0] ADDR_DATA = 2'h1;
	localparam logic [1:0] ADDR_MODE = 2'h2;
	localparam int MODE_EXT_RANGE_BIT = 0;

	// clock and timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_MHZ = 25;
	localparam int STEP_PULSE_NS = 1000;
	localparam int STEP_PULSE_CYCLES =
		(STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIME_UNIT_US = 1000;
	localparam int UNIT_CYCLES = TIME_UNIT_US * CLK_MHZ;
	localparam int STEP_RATE_SPAN = 16;

	// opcodes and masks
	localparam logic [7:0] OP_SEEK = 8'h0f;
	localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
	localparam logic [7:0] OP_SENSE_INT = 8'h08;
	localparam logic [7:0] OP_SPECIFY = 8'h03;
	localparam logic [7:0] OP_SET_TRACK = 8'h21;
	localparam logic [7:0] SET_TRACK_MASK = 8'hbf;
	localparam logic [7:0] SCAN_MASK = 8'h1f;
	localparam logic [7:0] OP_SCAN_EQUAL = 8'h11;
	localparam logic [7:0] OP_SCAN_LOW = 8'h19;
	localparam logic [7:0] OP_SCAN_HIGH = 8'h1d;

	// command lengths in bytes
	localparam logic [3:0] LEN_SEEK = 4'h3;
	localparam logic [3:0] LEN_SEEK_EXT = 4'h4;
	localparam logic [3:0] LEN_SENSE_DRIVE = 4'h2;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [3:0] LEN_THREE = 4'h3;
	localparam logic [3:0] LEN_SCAN = 4'h9;
	localparam logic [2:0] RES_SCAN = 3'h7;

	// status field positions and codes
	localparam int SCAN_HIT_BIT = 3;
	localparam int SCAN_MISS_BIT = 2;
	localparam int WRITE_PROTECT_BIT = 6;
	localparam int TRACK0_BIT = 4;
	localparam int REQUEST_BIT = 7;
	localparam int DIRECTION_BIT = 6;
	localparam int CMD_BUSY_BIT = 4;
	localparam logic [2:0] CODE_POLL_READY = 3'h6;
	localparam logic [2:0] CODE_SEEK_OK = 3'h1;
	localparam logic [2:0] CODE_SEEK_BAD = 3'h3;
	localparam logic [7:0] INVALID_STATUS = 8'h80;

	typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RESULT} phase_type;
	typedef enum logic [1:0] {SK_IDLE, SK_DELAY, SK_STEP} seek_phase_type;
	typedef enum logic [1:0] {SM_EQUAL, SM_LOW, SM_HIGH} scan_mode_type;
	typedef enum logic [2:0] {CK_SEEK, CK_SENSE_DRIVE, CK_SENSE_INT,
		CK_SPECIFY, CK_SET_TRACK, CK_SCAN, CK_INVALID} cmd_type;

	// opcode decode; scan flag bits 7-5 are ignored
	function automatic cmd_type decode(input logic [7:0] op);
		cmd_type k;
		k = CK_INVALID;
		if (op == OP_SEEK) begin
			k = CK_SEEK;
		end else if (op == OP_SENSE_DRIVE) begin
			k = CK_SENSE_DRIVE;
		end else if (op == OP_SENSE_INT) begin
			k = CK_SENSE_INT;
		end else if (op == OP_SPECIFY) begin
			k = CK_SPECIFY;
		end else if ((op & SET_TRACK_MASK) == OP_SET_TRACK) begin
			k = CK_SET_TRACK;
		end else if ((op & SCAN_MASK) == OP_SCAN_EQUAL ||
			(op & SCAN_MASK) == OP_SCAN_LOW ||
			(op & SCAN_MASK) == OP_SCAN_HIGH) begin
			k = CK_SCAN;
		end
		return k;
	endfunction

	// bytes in the command phase
	function automatic logic [3:0] cmd_length(input cmd_type k,
		input logic ext);
		logic [3:0] len;
		len = LEN_ONE;
		case (k)
			CK_SEEK: len = ext ? LEN_SEEK_EXT : LEN_SEEK;
			CK_SENSE_DRIVE: len = LEN_SENSE_DRIVE;
			CK_SPECIFY, CK_SET_TRACK: len = LEN_THREE;
			CK_SCAN: len = LEN_SCAN;
			default: len = LEN_ONE;
		endcase
		return len;
	endfunction

endpackage

// File: floppy_drive_model.sv
// Purpose: behavioural selected drive and scan compare engine
// Assumes: head starts at track 0; compare levels chosen by the bench
// Notes: compare levels invert outside the done pulse, so stale use shows
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_model (
	input wire logic mclk,
	input wire logic step_pulse,
	input wire logic head_dir,
	input wire logic scan_start,
	input wire logic eq_set,
	input wire logic low_set,
	output logic track0_pin,
	output logic scan_done,
	output logic scan_equal,
	output logic scan_disk_low
);
	int trk = 0; // head position
	logic step_q = 1'b0; // step edge detector
	logic [1:0] lag = 2'h0; // compare engine latency
	// head moves on each step rise and stops at track 0
	always @(posedge mclk) begin
		step_q <= step_pulse;
		if (step_pulse && !step_q) begin
			trk <= head_dir ? trk + 1 : (trk > 0 ? trk - 1 : 0);
		end
		lag <= {lag[0], scan_start};
		scan_done <= lag[1];
	end
	assign track0_pin = (trk == 0);
	assign scan_equal = scan_done ? eq_set : !eq_set;
	assign scan_disk_low = scan_done ? low_set : !low_set;
endmodule // floppy_drive_model
`default_nettype wire

// File: floppy_seek_sense_tb_top.sv
// Purpose: self-checking bench for the seek and sense sequencer
// Assumes: short time unit of 40 cycles, write protect held high
// Notes: host keeps to status reads and interrupt queries during a seek
`timescale 1ns/1ps
`default_nettype none
module floppy_seek_sense_tb_top;
	logic mclk = 1'b0, sys_rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [1:0] host_addr = 2'h0;
	logic [7:0] wr_data = 8'h00, rd_data, d;
	logic track0_pin, scan_done, scan_equal, scan_disk_low, scan_start;
	logic step_pulse, head_dir, int_req, eq_set = 1'b0, low_set = 1'b0;
	logic soft_rst = 1'b0;
	logic [1:0] scan_mode;
	int error_cnt = 0, checks = 0, cyc = 0;
	floppy_seek_sense #(.UNIT_CYCLES(40)) i_floppy_seek_sense (.mclk(mclk),
		.sys_rst(sys_rst), .soft_rst(soft_rst), .host_addr(host_addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rd_data(rd_data), .track0_pin(track0_pin),
		.write_protect_pin(1'b1), .drive_ready_pin(4'hf),
		.scan_done(scan_done), .scan_equal(scan_equal),
		.scan_disk_low(scan_disk_low), .scan_start(scan_start),
		.scan_mode(scan_mode), .step_pulse(step_pulse),
		.head_dir(head_dir), .int_req(int_req));
	floppy_drive_model i_floppy_drive_model (.mclk(mclk),
		.step_pulse(step_pulse), .head_dir(head_dir),
		.scan_start(scan_start), .eq_set(eq_set), .low_set(low_set),
		.track0_pin(track0_pin), .scan_done(scan_done),
		.scan_equal(scan_equal), .scan_disk_low(scan_disk_low));
	////////////////////////////////////////////////////////////////////
	// clock, and a ceiling on run length
	initial begin
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// one-cycle strobes, launched just after an edge
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge mclk);
		host_addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge mclk);
		host_addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 v = rd_data;
	endtask
	task automatic wait_int();
		for (int k = 0; k < 2000 && int_req !== 1'b1; k++) @(posedge mclk);
		chk("int_req", 8'h01, {7'h0, int_req});
	endtask
	task automatic sense_int(input logic [7:0] e0, e1);
		wr(2'h1, 8'h08);
		rd(2'h1, d);
		chk("status_zero", e0, d);
		rd(2'h1, d);
		chk("track_low", e1, d);
	endtask
	////////////////////////////////////////////////////////////////////
	// reset polling: one cause per drive, then none left
	task automatic test_poll();
		for (int i = 0; i < 4; i++) sense_int({6'h30, i[1:0]}, 8'h00);
		chk("int_after_read", 8'h00, {7'h0, int_req});
		wr(2'h1, 8'h08);
		rd(2'h1, d);
		chk("invalid_query", 8'h80, d);
	endtask
	// shortest interval, one unit delay, drive 1 in to track 5
	task automatic test_seek();
		wr(2'h1, 8'h03);
		wr(2'h1, 8'hf0);
		wr(2'h1, 8'h02);
		wr(2'h1, 8'h0f);
		wr(2'h1, 8'h01);
		wr(2'h1, 8'h05);
		rd(2'h0, d);
		chk("drive_busy", 8'h02, d & 8'h0f);
		wait_int();
		chk("steps", 8'h05, 8'(i_floppy_drive_model.trk));
		chk("head_dir", 8'h01, {7'h0, head_dir});
		sense_int(8'h21, 8'h05);
	endtask
	// off track 0, write protected, drive 1 head 0
	task automatic test_drive();
		wr(2'h1, 8'h04);
		wr(2'h1, 8'h01);
		rd(2'h1, d);
		chk("drive_state", 8'h41, d);
		chk("no_int", 8'h00, {7'h0, int_req});
	endtask
	// track 10 claimed at head 5: stepping out hits track 0 early
	task automatic test_track();
		wr(2'h1, 8'h61);
		wr(2'h1, 8'h01);
		wr(2'h1, 8'h0a);
		rd(2'h1, d);
		chk("set_track_low", 8'h0a, d);
		wr(2'h1, 8'h0f);
		wr(2'h1, 8'h01);
		wr(2'h1, 8'h00);
		wait_int();
		sense_int(8'h61, 8'h00);
		chk("head_out", 8'h00, {7'h0, head_dir});
		// high byte 1, then an extended seek onto the same track
		wr(2'h1, 8'h61);
		wr(2'h1, 8'h05);
		wr(2'h1, 8'h01);
		rd(2'h1, d);
		chk("set_track_high", 8'h01, d);
		wr(2'h2, 8'h01);
		wr(2'h1, 8'h0f);
		wr(2'h1, 8'h01);
		wr(2'h1, 8'h00);
		wr(2'h1, 8'h10);
		wait_int();
		sense_int(8'h21, 8'h00);
		rd(2'h1, d);
		chk("track_nibble", 8'h10, d);
		wr(2'h2, 8'h00);
	endtask
	// software reset re-arms drive polling
	task automatic test_soft();
		@(posedge mclk);
		soft_rst <= 1'b1;
		@(posedge mclk);
		soft_rst <= 1'b0;
		repeat (5) @(posedge mclk);
		test_poll();
	endtask
	// equal hit, low-or-equal met, high-or-equal failed
	task automatic test_scan();
		logic [7:0] ops [3] = '{8'h11, 8'h19, 8'h1d};
		logic [7:0] st2 [3] = '{8'h08, 8'h00, 8'h04};
		for (int i = 0; i < 3; i++) begin
			eq_set <= (i == 0);
			low_set <= (i != 0);
			wr(2'h1, ops[i]);
			wr(2'h1, 8'h01);
			wr(2'h1, 8'h03);
			for (int b = 0; b < 6; b++) wr(2'h1, 8'h01);
			#1 chk("scan_mode", {6'h0, i[1:0]}, {6'h0, scan_mode});
			wait_int();
			for (int j = 0; j < 7; j++) begin
				rd(2'h1, d);
				if (j == 2) chk("status_two", st2[i], d);
				if (j == 3) chk("scan_track", 8'h03, d);
			end
			chk("scan_int", 8'h00, {7'h0, int_req});
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (10) @(posedge mclk);
		test_poll();
		test_seek();
		test_drive();
		test_track();
		test_scan();
		test_soft();
		finish_test();
	end
endmodule // floppy_seek_sense_tb_top
`default_nettype wire
